// ===== inc/cbs_regs.svh
// cycle status codes, pin constants and fixed values for the bus sequencer
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH
`define CBS_ST_INT_ACK 3'h0
`define CBS_ST_IO_RD 3'h1
`define CBS_ST_IO_WR 3'h2
`define CBS_ST_PREFETCH 3'h4
`define CBS_ST_MEM_RD 3'h5
`define CBS_ST_MEM_WR 3'h6
`define CBS_ST_PASSIVE 3'h7
`define CBS_IO_TOP 4'h0
`define CBS_PCB_BASE_ZERO 16'h0000
`define CBS_PF_STEP_W 20'h00002
`define CBS_PF_STEP_B 20'h00001
`endif

// ===== inc/cbs_pkg.sv
// types and decode functions for the bus sequencer
`include "cbs_regs.svh"
package cbs_pkg;
    typedef enum logic [2:0] {
        K_MEM_RD = 3'h0,
        K_IO_RD = 3'h1,
        K_REFRESH = 3'h2,
        K_MEM_WR = 3'h3,
        K_IO_WR = 3'h4,
        K_INT_ACK = 3'h5,
        K_PREFETCH = 3'h6
    } cbs_kind_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_T1 = 6'h02,
        ST_T2 = 6'h04,
        ST_T3 = 6'h08,
        ST_TW = 6'h10,
        ST_T4 = 6'h20
    } cbs_state_t;

    function automatic logic cbs_is_write(input cbs_kind_t k);
        cbs_is_write = (k == K_MEM_WR) || (k == K_IO_WR);
    endfunction : cbs_is_write

    function automatic logic [2:0] cbs_status(input cbs_kind_t k);
        case (k)
            K_MEM_RD: cbs_status = `CBS_ST_MEM_RD;
            K_REFRESH: cbs_status = `CBS_ST_MEM_RD;
            K_IO_RD: cbs_status = `CBS_ST_IO_RD;
            K_PREFETCH: cbs_status = `CBS_ST_PREFETCH;
            K_MEM_WR: cbs_status = `CBS_ST_MEM_WR;
            K_IO_WR: cbs_status = `CBS_ST_IO_WR;
            K_INT_ACK: cbs_status = `CBS_ST_INT_ACK;
            default: cbs_status = `CBS_ST_PASSIVE;
        endcase
    endfunction : cbs_status
endpackage : cbs_pkg

// ===== core/cbs_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module cbs_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule : cbs_sync

// ===== core/cbs_pfq.sv
// instruction prefetch queue, shift style so the head is a flop
`timescale 1ns/10ps
module cbs_pfq #(
    parameter int W = 16,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    input wire logic i_push,
    input wire logic [W-1:0] i_data,
    input wire logic i_pop,
    output logic [W-1:0] o_data,
    output logic o_valid,
    output logic o_room
);
    logic [W-1:0] mem_q [DEPTH];
    logic [DEPTH-1:0] vld_q;
    logic [DEPTH:0] vs;
    logic [DEPTH-1:0] sv;
    wire do_pop = i_pop && vld_q[0];

    assign vs = {1'b0, vld_q};
    assign o_data = mem_q[0];
    assign o_valid = vld_q[0];
    // two free slots, so a cycle in flight always lands
    assign o_room = !vld_q[DEPTH-2];

    genvar g;
    for (g = 0; g < DEPTH; g++) begin : g_ent
        wire logic [W-1:0] nxt;
        wire logic here;
        assign sv[g] = do_pop ? vs[g+1] : vs[g];
        if (g == 0) begin : g_first
            assign here = i_push && !sv[g];
        end else begin : g_rest
            assign here = i_push && !sv[g] && sv[g-1];
        end
        if (g == DEPTH - 1) begin : g_last
            assign nxt = mem_q[g];
        end else begin : g_mid
            assign nxt = do_pop ? mem_q[g+1] : mem_q[g];
        end
        always_ff @(posedge i_clk) begin
            if (i_rst || i_flush) begin
                vld_q[g] <= 1'b0;
                mem_q[g] <= '0;
            end else begin
                vld_q[g] <= sv[g] | here;
                mem_q[g] <= here ? i_data : nxt;
            end
        end
    end
endmodule : cbs_pfq

// ===== core/cbs_seq.sv
// bus cycle sequencer: cycle state machine, strobes and address/data pins
`timescale 1ns/10ps
`include "cbs_regs.svh"
module cbs_seq #(
    parameter int DW = 16,
    parameter int PF_DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire cbs_pkg::cbs_kind_t i_req_kind,
    input wire logic [19:0] i_req_addr,
    input wire logic [15:0] i_req_wdata,
    input wire logic i_req_hbe_n,
    input wire logic i_pf_load,
    input wire logic [19:0] i_pf_addr,
    input wire logic i_pf_pop,
    input wire logic i_async_ready_in,
    input wire logic i_sync_ready_in,
    input wire logic [15:0] i_ad_in,
    input wire logic i_cascade_mode,
    input wire logic [15:0] i_pcb_base,
    output logic o_req_ready,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid,
    output logic [7:0] o_vector,
    output logic o_vector_valid,
    output logic [15:0] o_pf_data,
    output logic o_pf_valid,
    output logic o_ale,
    output logic [2:0] o_cycle_status_code,
    output logic [3:0] o_addr_top,
    output logic [15:0] o_ad_out,
    output logic o_ad_oe_lo,
    output logic o_ad_oe_hi,
    output logic o_high_byte_enable_n,
    output logic o_refresh_strobe_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_int_ack_strobe_n,
    output logic o_lock
);
    import cbs_pkg::*;

    // ----------------------------------------------------------------
    // pin sampling and ready
    // ----------------------------------------------------------------
    logic [17:0] pin_s;
    cbs_sync #(.W(18)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d({i_async_ready_in, i_sync_ready_in, i_ad_in}),
        .o_q(pin_s)
    );

    cbs_state_t st_q, st_d;
    cbs_kind_t kind_q, kind_d;
    logic [19:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;
    logic hbe_q, hbe_d;
    logic ack2_q, ack2_d;
    logic [19:0] pf_addr_q;
    logic pf_on_q, stale_q;
    logic q_room;

    wire bus_rdy = pin_s[17] | pin_s[16];
    wire ack_fast = (kind_q == K_INT_ACK) && i_cascade_mode
        && (i_pcb_base == `CBS_PCB_BASE_ZERO);
    wire rdy = bus_rdy | ack_fast;
    wire done = (st_q == ST_T4);
    wire at_end = done || (st_q == ST_IDLE);
    wire ack_more = done && (kind_q == K_INT_ACK) && !ack2_q;
    wire take = i_req_valid && o_req_ready;
    wire pf_go = at_end && !ack_more && !take && pf_on_q && q_room;
    wire start = ack_more || take || pf_go;
    wire [7:0] rd_hi = (DW == 16) ? pin_s[15:8] : 8'h00;
    wire [15:0] rd_word = {rd_hi, pin_s[7:0]};
    wire pf_push = done && (kind_q == K_PREFETCH) && !stale_q;
    wire [19:0] pf_step = (DW == 16) ? `CBS_PF_STEP_W : `CBS_PF_STEP_B;

    // ----------------------------------------------------------------
    // cycle state machine
    // ----------------------------------------------------------------
    always_comb begin
        case (st_q)
            ST_IDLE: st_d = start ? ST_T1 : ST_IDLE;
            ST_T4: st_d = start ? ST_T1 : ST_IDLE;
            ST_T1: st_d = ST_T2;
            ST_T2: st_d = ST_T3;
            ST_T3: st_d = rdy ? ST_T4 : ST_TW;
            ST_TW: st_d = rdy ? ST_T4 : ST_TW;
            default: st_d = ST_IDLE;
        endcase
    end

    always_comb begin
        kind_d = kind_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        hbe_d = hbe_q;
        ack2_d = ack2_q;
        if (ack_more) begin
            ack2_d = 1'b1;
        end else if (take) begin
            kind_d = i_req_kind;
            addr_d = i_req_addr;
            wdata_d = i_req_wdata;
            hbe_d = i_req_hbe_n;
            ack2_d = 1'b0;
        end else if (pf_go) begin
            kind_d = K_PREFETCH;
            addr_d = pf_addr_q;
            hbe_d = 1'b0;
            ack2_d = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // pin decode from next state
    // ----------------------------------------------------------------
    wire n_t1 = (st_d == ST_T1);
    wire n_stb = (st_d == ST_T2) || (st_d == ST_T3) || (st_d == ST_TW);
    wire n_busy = (st_d != ST_IDLE);
    wire n_ack = (kind_d == K_INT_ACK);
    wire n_wr = cbs_is_write(kind_d);
    wire n_refresh_strobe_n = (kind_d == K_REFRESH);
    wire n_io = (kind_d == K_IO_RD) || (kind_d == K_IO_WR);
    wire [19:0] n_addr = n_refresh_strobe_n ? {addr_d[19:1], 1'b1} : addr_d;
    wire [3:0] n_top = (n_io || n_ack) ? `CBS_IO_TOP : n_addr[19:16];
    wire [7:0] n_lo = n_t1 ? n_addr[7:0] : (n_wr ? wdata_d[7:0] : o_ad_out[7:0]);
    // 8-bit bus keeps A15:8 as plain address pins
    wire [7:0] n_hi = (n_t1 || DW == 8) ? n_addr[15:8]
        : (n_wr ? wdata_d[15:8] : o_ad_out[15:8]);
    wire n_oe_lo = n_t1 ? !n_ack : n_wr;
    wire n_oe_hi = n_ack ? 1'b0 : ((DW == 8) ? 1'b1 : n_oe_lo);
    wire n_hbe_n = (DW == 8) ? 1'b1 : (n_refresh_strobe_n ? 1'b1 : hbe_d);
    wire n_refresh_strobe_n_n = !((DW == 8) && n_busy && n_refresh_strobe_n);
    wire [2:0] n_stat = (n_t1 || st_d == ST_T2) ? cbs_status(kind_d)
        : `CBS_ST_PASSIVE;
    wire n_ready = (st_d == ST_IDLE) || ((st_d == ST_T4) && !(n_ack && !ack2_d));

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= ST_IDLE;
            kind_q <= K_MEM_RD;
            addr_q <= '0;
            wdata_q <= '0;
            hbe_q <= 1'b1;
            ack2_q <= 1'b0;
        end else begin
            st_q <= st_d;
            kind_q <= kind_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            hbe_q <= hbe_d;
            ack2_q <= ack2_d;
        end
    end

    // a reload during a prefetch cycle makes its data stale
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pf_addr_q <= '0;
            pf_on_q <= 1'b0;
            stale_q <= 1'b0;
        end else begin
            pf_on_q <= pf_on_q | i_pf_load;
            pf_addr_q <= i_pf_load ? i_pf_addr : (pf_go ? pf_addr_q + pf_step : pf_addr_q);
            stale_q <= i_pf_load ? (st_q != ST_IDLE || start) : (start ? 1'b0 : stale_q);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ale <= 1'b0;
            o_cycle_status_code <= `CBS_ST_PASSIVE;
            o_addr_top <= '0;
            o_ad_out <= '0;
            o_ad_oe_lo <= 1'b0;
            o_ad_oe_hi <= 1'b0;
            o_high_byte_enable_n <= 1'b1;
            o_refresh_strobe_n <= 1'b1;
            o_rd_n <= 1'b1;
            o_wr_n <= 1'b1;
            o_int_ack_strobe_n <= 1'b1;
            o_lock <= 1'b0;
            o_req_ready <= 1'b0;
        end else begin
            o_ale <= n_t1;
            o_cycle_status_code <= n_stat;
            o_req_ready <= n_ready;
            o_rd_n <= !(n_stb && !n_wr && !n_ack);
            o_wr_n <= !(n_stb && n_wr);
            o_int_ack_strobe_n <= !(n_stb && n_ack);
            o_lock <= n_busy && n_ack;
            o_refresh_strobe_n <= n_refresh_strobe_n_n;
            // idle keeps the pins as the last cycle left them
            if (n_busy) begin
                o_addr_top <= n_top;
                o_ad_out <= {n_hi, n_lo};
                o_ad_oe_lo <= n_oe_lo;
                o_ad_oe_hi <= n_oe_hi;
                o_high_byte_enable_n <= n_hbe_n;
            end
        end
    end

    // ----------------------------------------------------------------
    // returned data
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_data <= '0;
            o_rd_valid <= 1'b0;
            o_vector <= '0;
            o_vector_valid <= 1'b0;
        end else begin
            o_rd_valid <= done && (kind_q == K_MEM_RD || kind_q == K_IO_RD);
            if (done) begin
                o_rd_data <= rd_word;
            end
            o_vector_valid <= done && (kind_q == K_INT_ACK) && ack2_q;
            if (done && kind_q == K_INT_ACK && ack2_q) begin
                o_vector <= pin_s[7:0];
            end
        end
    end

    cbs_pfq #(.W(16), .DEPTH(PF_DEPTH)) u_pfq (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_flush(i_pf_load),
        .i_push(pf_push),
        .i_data(rd_word),
        .i_pop(i_pf_pop),
        .o_data(o_pf_data),
        .o_valid(o_pf_valid),
        .o_room(q_room)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_ale_status: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ale |-> o_cycle_status_code != `CBS_ST_PASSIVE ##1 !o_ale)
        else $error("latch strobe without status");

    a_memrd_code: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ale && kind_q == K_MEM_RD |-> o_cycle_status_code == `CBS_ST_MEM_RD
        && o_addr_top == addr_q[19:16] && o_ad_out == addr_q[15:0])
        else $error("memory read address or code wrong");

    a_iord_top: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ale && kind_q == K_IO_RD |-> o_addr_top == `CBS_IO_TOP)
        else $error("io read top bits not zero");

    a_iowr_code: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ale && kind_q == K_IO_WR |-> o_cycle_status_code == `CBS_ST_IO_WR
        && o_addr_top == `CBS_IO_TOP && o_ad_out == addr_q[15:0])
        else $error("io write code or address wrong");

    a_memwr_code: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ale && kind_q == K_MEM_WR |-> o_cycle_status_code == `CBS_ST_MEM_WR
        && o_addr_top == addr_q[19:16])
        else $error("memory write code or address wrong");

    a_wr_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_wr_n) |-> o_ad_oe_lo && o_ad_out == $past(o_ad_out))
        else $error("write data dropped at strobe end");

    a_wait_wr: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == ST_TW && cbs_is_write(kind_q) |-> !o_wr_n)
        else $error("write strobe not stretched by wait");

    a_wait_entry: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == ST_T3 && !rdy |=> st_q == ST_TW)
        else $error("no wait state while not ready");

    a_ready_or: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == ST_TW && (pin_s[17] || pin_s[16]) |=> st_q == ST_T4)
        else $error("either ready did not end the wait");

    a_ack_lock: assert property (@(posedge i_clk) disable iff (i_rst)
        ack_more |=> o_lock && o_ale && ack2_q)
        else $error("second acknowledge not locked");

    a_ack_strobe: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_int_ack_strobe_n |-> o_rd_n && o_lock)
        else $error("acknowledge strobe with read strobe");

    a_ack_float: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ale && kind_q == K_INT_ACK |-> !o_ad_oe_lo && !o_ad_oe_hi)
        else $error("address driven during acknowledge");

    a_vec_take: assert property (@(posedge i_clk) disable iff (i_rst)
        done && kind_q == K_INT_ACK && ack2_q |=> o_vector_valid
        && o_vector == $past(pin_s[7:0]))
        else $error("vector not captured from low byte");

    a_refresh_strobe_n_pins: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ale && kind_q == K_REFRESH |-> o_ad_out[0]
        && (DW == 16 ? o_high_byte_enable_n : !o_refresh_strobe_n))
        else $error("refresh pins wrong");

    a_ack_fast: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == ST_T3 && ack_fast |=> st_q == ST_T4)
        else $error("wait added to fast acknowledge");

    a_pf_push: assert property (@(posedge i_clk) disable iff (i_rst)
        pf_push && !i_pf_load |=> o_pf_valid)
        else $error("prefetch data not queued");

    a_ack_top: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ale && kind_q == K_INT_ACK |-> o_addr_top == `CBS_IO_TOP)
        else $error("acknowledge top bits not zero");

    a_byte_pins: assert property (@(posedge i_clk) disable iff (i_rst)
        (DW == 8) ? o_high_byte_enable_n : o_refresh_strobe_n)
        else $error("pin unused at this bus width left active");
endmodule : cbs_seq

// ===== tb/cbs_bus_model.sv
// memory, port and interrupt controller model on the far side of the bus
`timescale 1ns/10ps
module cbs_bus_model #(
    parameter logic [7:0] VEC = 8'h5a
) (
    input wire logic i_clk,
    input wire logic i_ale,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_int_ack_strobe_n,
    input wire logic [15:0] i_ad_out,
    input wire logic i_ad_oe_lo,
    input wire logic i_ad_oe_hi,
    input wire logic [3:0] i_waits,
    input wire logic [1:0] i_pins,
    output logic [15:0] o_ad_in,
    output logic o_async_ready_in,
    output logic o_sync_ready_in
);
    logic [15:0] mem [16];
    logic [15:0] last_q = 16'h0000;
    logic [15:0] drv_v;
    logic [3:0] idx_q = 4'h0;
    logic [3:0] cnt_q = 4'h0;
    logic [7:0] tick_q = 8'h00;
    logic wr_prev_q = 1'b1;
    logic drive;
    logic pull;
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'ha500 + 16'(i);
        end
    end
    // --------------------------------
    // data lines: a released bus shows the inverse of its last level
    // --------------------------------
    assign drive = !i_rd_n || !i_int_ack_strobe_n;
    // no address decode on acknowledge, upper byte toggles
    assign drv_v = !i_int_ack_strobe_n ? {tick_q, VEC} : mem[idx_q];
    assign o_ad_in[15:8] = i_ad_oe_hi ? i_ad_out[15:8] : (drive ? drv_v[15:8] : ~last_q[15:8]);
    assign o_ad_in[7:0] = i_ad_oe_lo ? i_ad_out[7:0] : (drive ? drv_v[7:0] : ~last_q[7:0]);
    // --------------------------------
    // ready: normally ready, pulled low i_waits clocks from the latch strobe
    // --------------------------------
    assign pull = (i_ale && i_waits != 4'h0) || cnt_q != 4'h0;
    assign o_async_ready_in = !(pull && i_pins[0]);
    assign o_sync_ready_in = !(pull && i_pins[1]);
    always @(posedge i_clk) begin
        tick_q <= tick_q + 8'h01;
        last_q <= o_ad_in;
        wr_prev_q <= i_wr_n;
        if (i_ale) begin
            idx_q <= i_ad_out[4:1];
            cnt_q <= (i_waits != 4'h0) ? i_waits - 4'h1 : 4'h0;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
        // capture on the rising write strobe
        if (!wr_prev_q && i_wr_n) begin
            mem[idx_q] <= o_ad_in;
        end
    end
endmodule : cbs_bus_model

// ===== tb/test_cpu_bus_cycle_sequencer.sv
// self-checking bench for the bus cycle sequencer
`timescale 1ns/10ps
`include "cbs_regs.svh"
module test_cpu_bus_cycle_sequencer;
    import cbs_pkg::*;
    localparam logic [7:0] VEC = 8'h5a;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_req_valid = 1'b0;
    cbs_kind_t i_req_kind = K_MEM_RD;
    logic [19:0] i_req_addr = 20'h00000;
    logic [15:0] i_req_wdata = 16'h0000;
    logic i_req_hbe_n = 1'b0;
    logic i_pf_load = 1'b0;
    logic [19:0] i_pf_addr = 20'h00000;
    logic i_pf_pop = 1'b0;
    logic i_cascade_mode = 1'b0;
    logic [15:0] i_pcb_base = 16'h0100;
    logic [3:0] m_w = 4'h0;
    logic [1:0] m_pins = 2'h3;
    wire logic ar;
    wire logic sr;
    wire logic [15:0] ad_in;
    logic o_req_ready, o_rd_valid, o_vector_valid, o_pf_valid, o_ale, o_ad_oe_lo, o_ad_oe_hi;
    logic o_high_byte_enable_n, o_refresh_strobe_n, o_rd_n, o_wr_n, o_int_ack_strobe_n, o_lock;
    logic [15:0] o_rd_data, o_pf_data, o_ad_out, a_ad, e_ad;
    logic [7:0] o_vector;
    logic [2:0] o_cycle_status_code, a_st;
    logic [3:0] o_addr_top, a_top;
    logic a_hbe, a_oe, e_oe, lk;
    wire logic strb = o_rd_n & o_wr_n & o_int_ack_strobe_n;
    int n_errors = 0, compares = 0, n_cyc = 0, run = 0, rise_t = 0, gap = 0, n_end = 0;
    int n_ale = 0, n_rv = 0, n_vv = 0, n_rd = 0, lmin = 0, lmax = 0;
    cbs_seq #(.DW(16), .PF_DEPTH(4)) i_cbs_seq (.i_clk(i_clk), .i_rst(i_rst),
        .i_req_valid(i_req_valid), .i_req_kind(i_req_kind), .i_req_addr(i_req_addr),
        .i_req_wdata(i_req_wdata), .i_req_hbe_n(i_req_hbe_n), .i_pf_load(i_pf_load),
        .i_pf_addr(i_pf_addr), .i_pf_pop(i_pf_pop), .i_async_ready_in(ar), .i_sync_ready_in(sr),
        .i_ad_in(ad_in), .i_cascade_mode(i_cascade_mode), .i_pcb_base(i_pcb_base),
        .o_req_ready(o_req_ready), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
        .o_vector(o_vector), .o_vector_valid(o_vector_valid), .o_pf_data(o_pf_data),
        .o_pf_valid(o_pf_valid), .o_ale(o_ale), .o_cycle_status_code(o_cycle_status_code),
        .o_addr_top(o_addr_top), .o_ad_out(o_ad_out), .o_ad_oe_lo(o_ad_oe_lo),
        .o_ad_oe_hi(o_ad_oe_hi), .o_high_byte_enable_n(o_high_byte_enable_n),
        .o_refresh_strobe_n(o_refresh_strobe_n), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
        .o_int_ack_strobe_n(o_int_ack_strobe_n), .o_lock(o_lock));
    cbs_bus_model #(.VEC(VEC)) i_cbs_bus_model (.i_clk(i_clk), .i_ale(o_ale), .i_rd_n(o_rd_n),
        .i_wr_n(o_wr_n), .i_int_ack_strobe_n(o_int_ack_strobe_n), .i_ad_out(o_ad_out),
        .i_ad_oe_lo(o_ad_oe_lo), .i_ad_oe_hi(o_ad_oe_hi), .i_waits(m_w), .i_pins(m_pins),
        .o_ad_in(ad_in), .o_async_ready_in(ar), .o_sync_ready_in(sr));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    // --------------------------------
    // monitor: latch strobe capture, strobe length, gap to next cycle
    // --------------------------------
    always @(posedge i_clk) begin
        n_cyc++;
        if (o_ale === 1'b1) begin
            a_st = o_cycle_status_code;
            a_top = o_addr_top;
            a_ad = o_ad_out;
            a_hbe = o_high_byte_enable_n;
            a_oe = o_ad_oe_lo | o_ad_oe_hi;
            n_ale++;
            gap = n_cyc - rise_t;
        end
        if (o_ale === 1'b1 || strb === 1'b0) lk = lk & o_lock;
        if (o_rd_n === 1'b0) n_rd++;
        if (o_rd_valid === 1'b1) n_rv++;
        if (o_vector_valid === 1'b1) n_vv++;
        if (strb === 1'b0) begin
            run++;
        end else if (run != 0) begin
            lmin = (run < lmin) ? run : lmin;
            lmax = (run > lmax) ? run : lmax;
            run = 0;
            rise_t = n_cyc;
            n_end++;
            e_oe = o_ad_oe_lo;
            e_ad = o_ad_out;
        end
        // ceiling well above the whole sequence
        if (n_cyc == 4000) begin
            n_errors++;
            stop_test();
        end
    end
    // --------------------------------
    // shared tasks
    // --------------------------------
    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic clear(input int w, input logic [1:0] p);
        m_w = 4'(w);
        m_pins = p;
        lmin = 99;
        lmax = 0;
        lk = 1'b1;
        n_ale = 0;
        n_rv = 0;
        n_vv = 0;
        n_rd = 0;
    endtask : clear
    // holds the request until n takes at edges with ready high
    task automatic req(input cbs_kind_t k, input logic [19:0] a, input logic [15:0] d,
                       input int n);
        logic r;
        int t;
        t = 0;
        i_req_valid = 1'b1;
        i_req_kind = k;
        i_req_addr = a;
        i_req_wdata = d;
        for (int g = 0; g < 400 && t < n; g++) begin
            r = o_req_ready;
            @(posedge i_clk);
            #1;
            if (r === 1'b1) t++;
        end
        i_req_valid = 1'b0;
        chk(t == n, "request not taken");
    endtask : req
    task automatic wait_end(input int e);
        for (int g = 0; g < 400 && n_end < e; g++) begin
            @(posedge i_clk);
            #1;
        end
        repeat (2) @(posedge i_clk);
        #1;
        chk(n_end >= e, "cycle did not end");
    endtask : wait_end
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_rw();
        int e;
        logic io;
        for (int i = 0; i < 2; i++) begin
            io = (i == 1);
            clear(0, 2'h3);
            e = n_end;
            req(io ? K_IO_WR : K_MEM_WR, 20'hf0002 + 20'(i * 2), 16'h1234 + 16'(i), 1);
            wait_end(e + 1);
            chk(a_st === (io ? `CBS_ST_IO_WR : `CBS_ST_MEM_WR), "write status");
            chk({a_top, a_ad} === (io ? 20'h00004 : 20'hf0002), "write address");
            chk(lmin == 2 && lmax == 2, "write pulse");
            chk(e_oe === 1'b1 && e_ad === 16'h1234 + 16'(i), "write data hold");
            req(io ? K_IO_RD : K_MEM_RD, 20'hf0002 + 20'(i * 2), 16'h0000, 1);
            wait_end(e + 2);
            chk(a_st === (io ? `CBS_ST_IO_RD : `CBS_ST_MEM_RD), "read status");
            chk({a_top, a_ad} === (io ? 20'h00004 : 20'hf0002), "read address");
            chk(a_hbe === 1'b0, "read byte enable");
            chk(o_rd_data === 16'h1234 + 16'(i) && n_rv == 1, "read data");
        end
    endtask : t_rw
    task automatic t_wait();
        int e;
        int w [4] = '{0, 3, 3, 3};
        logic [1:0] p [4] = '{2'h3, 2'h3, 2'h1, 2'h2};
        for (int i = 0; i < 4; i++) begin
            clear(w[i], p[i]);
            e = n_end;
            req(K_MEM_WR, 20'h00006, 16'h0bad, 2);
            wait_end(e + 2);
            // a single pin held ready keeps the bus ready
            chk(lmin == ((p[i] == 2'h3) ? w[i] + 2 : 2) && lmin == lmax, "wait length");
            chk(gap == 1, "write recovery");
        end
    endtask : t_wait
    task automatic t_refresh();
        int e;
        clear(0, 2'h3);
        e = n_end;
        req(K_REFRESH, 20'h00010, 16'h0000, 1);
        wait_end(e + 1);
        chk(a_ad[0] === 1'b1 && a_hbe === 1'b1, "refresh address");
        chk(a_st === `CBS_ST_MEM_RD && n_rv == 0, "refresh read");
        chk(o_refresh_strobe_n === 1'b1, "refresh strobe on wide bus");
    endtask : t_refresh
    task automatic t_ack();
        int e;
        logic c [3] = '{1'b0, 1'b1, 1'b1};
        logic [15:0] b [3] = '{16'h0100, 16'h0000, 16'h0100};
        int x [3] = '{2, 2, 6};
        for (int i = 0; i < 3; i++) begin
            clear(3 * i / 2 + i / 2, 2'h3);
            i_cascade_mode = c[i];
            i_pcb_base = b[i];
            e = n_end;
            req(K_INT_ACK, 20'hfffff, 16'h0000, 1);
            wait_end(e + 2);
            chk(n_ale == 2 && lk === 1'b1 && a_st === `CBS_ST_INT_ACK, "ack pair");
            chk(n_rd == 0, "ack strobe");
            chk(a_top === `CBS_IO_TOP && a_oe === 1'b0, "ack address");
            chk(o_vector === VEC && n_vv == 1 && n_rv == 0, "vector");
            chk(lmin == x[i] && lmax == x[i], "ack waits");
        end
        i_cascade_mode = 1'b0;
    endtask : t_ack
    task automatic t_pf();
        i_pf_addr = 20'h00010;
        i_pf_load = 1'b1;
        @(posedge i_clk);
        #1;
        i_pf_load = 1'b0;
        for (int g = 0; g < 100 && o_pf_valid !== 1'b1; g++) begin
            @(posedge i_clk);
            #1;
        end
        chk(o_pf_data === 16'ha508 && a_st === `CBS_ST_PREFETCH, "prefetch head");
        i_pf_pop = 1'b1;
        @(posedge i_clk);
        #1;
        i_pf_pop = 1'b0;
        // a lone entry empties the queue, so wait for the next fill
        for (int g = 0; g < 100 && o_pf_valid !== 1'b1; g++) begin
            @(posedge i_clk);
            #1;
        end
        chk(o_pf_data === 16'ha509 && o_pf_valid === 1'b1, "prefetch next");
    endtask : t_pf
    task automatic stop_test();
        if (n_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (10) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        t_rw();
        t_wait();
        t_refresh();
        t_ack();
        t_pf();
        stop_test();
    end
endmodule : test_cpu_bus_cycle_sequencer
